/* File: pkg/smc_pkg.sv */
package smc_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] SMC_ADDR_SYSCR_ONE = 8'h38;
  localparam logic [7:0] SMC_ADDR_SYSCR_TWO = 8'h39;
  localparam logic [7:0] SMC_ADDR_STATUS = 8'h3A;
  localparam int SMC_B_STOP = 7;
  localparam int SMC_B_STOP_RELEASE_METHOD = 6;
  localparam int SMC_B_STOP_RETURN_MODE = 5;
  localparam int SMC_B_OUTEN = 4;
  localparam int SMC_B_WUT_HI = 3;
  localparam int SMC_B_WUT_LO = 2;
  localparam int SMC_B_XEN = 7;
  localparam int SMC_B_ZERO = 6;
  localparam int SMC_B_SYSCLK_SELECT = 5;
  localparam int SMC_B_IDLE = 4;
  localparam logic [7:0] SMC_SYSCR_ONE_RST = 8'h00;
  localparam logic [3:0] SMC_SYSCR_TWO_RST = 4'h8;
  localparam logic [3:0] SMC_UNDEF_READ = 4'h0;
  // ----------------------------------------
  // warm-up lengths in fc periods
  // ----------------------------------------
  localparam logic [1:0] SMC_WUT_LONG = 2'h0;
  localparam logic [1:0] SMC_WUT_MID = 2'h1;
  localparam logic [1:0] SMC_WUT_SHORT = 2'h2;
  localparam logic [19:0] SMC_WARM_LONG = 20'h30000;
  localparam logic [19:0] SMC_WARM_MID = 20'h10000;
  localparam logic [19:0] SMC_WARM_SHORT = 20'h04000;
  localparam int SMC_DIV_W = 24;
  typedef enum logic [1:0]
  {
    SMC_NORMAL = 2'b00,
    SMC_STOP = 2'b01,
    SMC_WARM = 2'b11,
    SMC_IDLE = 2'b10
  } smc_mode_e;
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } smc_bus_s;
endpackage

/* File: hdl/smc_standby_ctrl.sv */
module smc_standby_ctrl
  import smc_pkg::*;
#(
  parameter int WARM_SCALE = 1
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire smc_bus_s bus,
  output logic [7:0] rdata,
  input wire logic stop_n_pin,
  input wire logic [7:0] ext_int_pins,
  input wire logic wake_irq,
  input wire logic master_int_enable,
  input wire logic divider_stage1_select,
  output logic osc_enable_out,
  output logic cpu_run,
  output logic watchdog_run,
  output logic periph_run,
  output logic int_service,
  output logic sys_reset_req,
  output logic [7:0] int_latch_set,
  output logic [SMC_DIV_W-1:0] divider
);
  initial
  begin
    if (WARM_SCALE < 1 || WARM_SCALE > 16) $error("WARM_SCALE out of range");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  smc_mode_e mode;
  logic stop_req, stop_release_method, stop_return_mode, outen;
  logic [1:0] warmup_select;
  logic osc_enable, sysclk_select, idle_req;
  logic pin_q, edge_armed;
  logic [7:0] ext_q;
  logic [20:0] warm_cnt;
  logic [20:0] warm_len;
  logic rise;

  function automatic logic [20:0] warm_cycles(input logic [1:0] sel, input logic dbl);
    logic [19:0] base;
    base = SMC_WARM_SHORT;
    unique case (sel)
      SMC_WUT_LONG: base = SMC_WARM_LONG;
      SMC_WUT_MID: base = SMC_WARM_MID;
      default: base = SMC_WARM_SHORT;
    endcase
    return dbl ? {base, 1'b0} : {1'b0, base};
  endfunction

  assign warm_len = warm_cycles(warmup_select, divider_stage1_select) / 21'(WARM_SCALE);
  assign rise = stop_n_pin & ~pin_q;
  wire wr1 = bus.wr && bus.addr == SMC_ADDR_SYSCR_ONE;
  wire wr2 = bus.wr && bus.addr == SMC_ADDR_SYSCR_TWO;
  wire stop_go = wr1 && bus.wdata[SMC_B_STOP] && mode == SMC_NORMAL;
  // a stop request with level release and pin high never halts the oscillator
  wire stop_enter = stop_go && !(bus.wdata[SMC_B_STOP_RELEASE_METHOD] && stop_n_pin);
  wire idle_go = wr2 && bus.wdata[SMC_B_IDLE] && mode == SMC_NORMAL;

  always_ff @(posedge mclk)
  begin
    if (reset)
      pin_q <= 1'b0;
    else
      pin_q <= stop_n_pin;
  end

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  // reset is synchronous but external reset in stop still wins at once
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mode <= SMC_NORMAL;
      warm_cnt <= '0;
      edge_armed <= 1'b0;
    end
    else
    begin
      unique case (mode)
        SMC_NORMAL:
        begin
          warm_cnt <= '0;
          edge_armed <= 1'b0;
          if (stop_go)
          begin
            if (bus.wdata[SMC_B_STOP_RELEASE_METHOD] && stop_n_pin)
              mode <= SMC_WARM;
            else
              mode <= SMC_STOP;
          end
          else if (wr2 && bus.wdata[SMC_B_IDLE])
            mode <= SMC_IDLE;
        end
        SMC_STOP:
        begin
          // edge mode needs a rising edge; a later switch to level keeps that need
          if (!stop_release_method)
            edge_armed <= 1'b1;
          if (rise || (stop_release_method && !edge_armed && stop_n_pin))
            mode <= SMC_WARM;
        end
        SMC_WARM:
        begin
          warm_cnt <= warm_cnt + 21'h000001;
          if (warm_cnt + 21'h000001 >= warm_len)
            mode <= SMC_NORMAL;
        end
        SMC_IDLE:
        begin
          if (wake_irq)
            mode <= SMC_NORMAL;
        end
        default: mode <= SMC_NORMAL;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      stop_req <= SMC_SYSCR_ONE_RST[SMC_B_STOP];
      stop_release_method <= SMC_SYSCR_ONE_RST[SMC_B_STOP_RELEASE_METHOD];
      stop_return_mode <= SMC_SYSCR_ONE_RST[SMC_B_STOP_RETURN_MODE];
      outen <= SMC_SYSCR_ONE_RST[SMC_B_OUTEN];
      warmup_select <= SMC_SYSCR_ONE_RST[SMC_B_WUT_HI:SMC_B_WUT_LO];
    end
    else
    begin
      if (wr1 && mode != SMC_STOP)
      begin
        stop_req <= bus.wdata[SMC_B_STOP];
        stop_release_method <= bus.wdata[SMC_B_STOP_RELEASE_METHOD];
        stop_return_mode <= bus.wdata[SMC_B_STOP_RETURN_MODE];
        outen <= bus.wdata[SMC_B_OUTEN];
        if (bus.wdata[SMC_B_WUT_HI:SMC_B_WUT_LO] != 2'h3)
          warmup_select <= bus.wdata[SMC_B_WUT_HI:SMC_B_WUT_LO];
      end
      if (mode == SMC_WARM && warm_cnt + 21'h000001 >= warm_len)
        stop_req <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      osc_enable <= SMC_SYSCR_TWO_RST[3];
      sysclk_select <= SMC_SYSCR_TWO_RST[1];
      idle_req <= SMC_SYSCR_TWO_RST[0];
    end
    else
    begin
      if (wr2 && mode == SMC_NORMAL)
      begin
        osc_enable <= bus.wdata[SMC_B_XEN];
        sysclk_select <= bus.wdata[SMC_B_SYSCLK_SELECT];
        idle_req <= bus.wdata[SMC_B_IDLE];
      end
      if (mode == SMC_IDLE && wake_irq)
        idle_req <= 1'b0;
      if (mode == SMC_WARM && !stop_return_mode)
      begin
        osc_enable <= 1'b1;
        sysclk_select <= 1'b0;
      end
    end
  end

  // clock off or reserved clock would lock the cpu, so reset instead
  always_ff @(posedge mclk)
  begin
    if (reset)
      sys_reset_req <= 1'b0;
    else
      sys_reset_req <= !osc_enable || sysclk_select;
  end

  // ----------------------------------------
  // timing generator divider
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset || stop_go || mode == SMC_STOP || mode == SMC_WARM)
      divider <= '0;
    else
      divider <= divider + 24'h000001;
  end

  // ----------------------------------------
  // interrupt latch capture during stop and warm-up
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ext_q <= 8'h00;
      int_latch_set <= 8'h00;
    end
    else
    begin
      ext_q <= ext_int_pins;
      if (mode == SMC_STOP || mode == SMC_WARM)
        int_latch_set <= ext_int_pins ^ ext_q;
      else
        int_latch_set <= 8'h00;
    end
  end

  // ----------------------------------------
  // run controls
  // ----------------------------------------
  // state is held simply because the cpu gets no run enable
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cpu_run <= 1'b1;
      watchdog_run <= 1'b1;
      periph_run <= 1'b1;
      osc_enable_out <= 1'b1;
      int_service <= 1'b0;
    end
    else
    begin
      // run enables follow the request edge so nothing runs a cycle into the new mode
      cpu_run <= mode == SMC_NORMAL && !stop_go && !idle_go;
      watchdog_run <= mode == SMC_NORMAL && !stop_go && !idle_go;
      periph_run <= (mode == SMC_NORMAL && !stop_go) || mode == SMC_IDLE;
      osc_enable_out <= mode != SMC_STOP && !stop_enter;
      int_service <= mode == SMC_IDLE && wake_irq && master_int_enable;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      unique case (bus.addr)
        SMC_ADDR_SYSCR_ONE: rdata <= {stop_req, stop_release_method, stop_return_mode, outen, warmup_select, 2'b00};
        SMC_ADDR_SYSCR_TWO: rdata <= {osc_enable, 1'b0, sysclk_select, idle_req,
          SMC_UNDEF_READ};
        SMC_ADDR_STATUS: rdata <= {6'h00, mode};
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule

/* File: testbench/smc_props.sv */
module smc_props
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire smc_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic stop_n_pin,
  input wire logic [7:0] ext_int_pins,
  input wire logic wake_irq,
  input wire logic master_int_enable,
  input wire logic divider_stage1_select,
  input wire logic osc_enable_out,
  input wire logic cpu_run,
  input wire logic watchdog_run,
  input wire logic periph_run,
  input wire logic int_service,
  input wire logic sys_reset_req,
  input wire logic [7:0] int_latch_set,
  input wire logic [SMC_DIV_W-1:0] divider
);
  // ----------------------------------------
  // mode relations
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_stop_entry:
  assert property (bus.wr && bus.addr == SMC_ADDR_SYSCR_ONE && bus.wdata[7] && cpu_run
    |=> !cpu_run && !periph_run) else $error("stop write left cpu running");
  chk_idle_entry:
  assert property (bus.wr && bus.addr == SMC_ADDR_SYSCR_TWO && bus.wdata[7:4] == 4'h9
    && cpu_run |=> !cpu_run && !watchdog_run && periph_run) else $error("idle not entered");
  chk_osc_halt:
  assert property (!osc_enable_out |-> !cpu_run && !periph_run) else $error("osc off, logic on");
  chk_div_zero:
  assert property (!periph_run && $past(!periph_run) |-> divider == '0)
    else $error("divider runs while stopped");
  chk_warm_holds:
  assert property (osc_enable_out && !periph_run |=> osc_enable_out)
    else $error("warm-up fell back to stop");
  chk_xen_reset:
  assert property (bus.wr && bus.addr == SMC_ADDR_SYSCR_TWO && !bus.wdata[7] && cpu_run
    |-> ##[1:2] sys_reset_req) else $error("oscillator clear without reset");
  chk_idle_int:
  assert property (!cpu_run && periph_run && wake_irq && master_int_enable && !int_service
    |-> ##[1:2] int_service) else $error("idle release skipped interrupt");
  chk_latch_quiet:
  assert property (cpu_run && $past(cpu_run) && $past(cpu_run, 2) |-> int_latch_set == 8'h00)
    else $error("latch pulse in normal mode");
endmodule
bind smc_standby_ctrl smc_props u_props (.*);

/* File: testbench/smc_wake_src.sv */
module smc_wake_src
(
  input wire logic mclk,
  input wire logic goal,
  input wire logic [2:0] lag,
  output logic stop_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // wake source follows goal lag+1 cycles after it changes
  // ----------------------------------------
  // the lag models slow wake sources, so release never lands on a fixed cycle
  logic [2:0] cnt = 3'h0;
  initial stop_n_pin = 1'b0;
  always @(posedge mclk)
  begin
    if (stop_n_pin == goal)
      cnt <= 3'h0;
    else if (cnt >= lag)
      stop_n_pin <= goal;
    else
      cnt <= cnt + 3'h1;
  end
endmodule

/* File: testbench/smc_standby_ctrl_test.sv */
module smc_standby_ctrl_test
  import smc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SCALE = 16;
  logic mclk, reset, wake, mie, div1, goal, pin_n, osc, cpu, wdg, per, isv, rreq;
  logic [2:0] lag;
  logic [7:0] ext, rdata, latch, v;
  logic [SMC_DIV_W-1:0] divider;
  smc_bus_s bus;
  int bad_count, samples_checked, n, e, seed;
  logic seen;
  smc_wake_src u_wake (.mclk(mclk), .goal(goal), .lag(lag), .stop_n_pin(pin_n));
  smc_standby_ctrl #(.WARM_SCALE(SCALE)) u_dut (.mclk(mclk), .reset(reset), .bus(bus),
    .rdata(rdata), .stop_n_pin(pin_n), .ext_int_pins(ext), .wake_irq(wake),
    .master_int_enable(mie), .divider_stage1_select(div1), .osc_enable_out(osc),
    .cpu_run(cpu), .watchdog_run(wdg), .periph_run(per), .int_service(isv),
    .sys_reset_req(rreq), .int_latch_set(latch), .divider(divider));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] x);
    samples_checked++;
    if (s !== x)
    begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus <= '0;
    #1 v = rdata;
  endtask
  task automatic pin(input logic p);
    goal <= p;
    n = 0;
    while (pin_n !== p && n < 20) @(posedge mclk) n++;
    if (pin_n !== p)
    begin
      bad_count++;
      final_report();
    end
  endtask
  task automatic wait_run();
    n = 0;
    while (cpu !== 1'b1 && n < 40000) @(posedge mclk) #1 n++;
    if (n >= 40000)
    begin
      bad_count++;
      final_report();
    end
  endtask
  function automatic int warm_exp(int c, logic d);
    logic [19:0] b;
    b = (c == 0) ? SMC_WARM_LONG : (c == 1) ? SMC_WARM_MID : SMC_WARM_SHORT;
    return (int'(b) << d) / SCALE;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    {reset, wake, mie, div1, goal, lag, ext, bus} = '0;
    reset = 1'b1;
    seed = $urandom(29);
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(SMC_ADDR_SYSCR_TWO);
    chk("sysctl2", v, {SMC_SYSCR_TWO_RST, SMC_UNDEF_READ});
    rd(SMC_ADDR_SYSCR_ONE);
    chk("sysctl1", v[7:2], SMC_SYSCR_ONE_RST[7:2]);
    rd(8'h50);
    chk("unmapped", v, 8'h00);
    for (int c = 0; c < 3; c++)
    begin
      div1 <= 1'($urandom);
      lag <= 3'($urandom);
      pin(1'b1);
      wr(SMC_ADDR_SYSCR_ONE, 8'h90 | 8'(c << 2));
      rd(SMC_ADDR_STATUS);
      chk("edge stop", v[1:0], SMC_STOP);
      chk("osc off", osc, 1'b0);
      seen = 1'b0;
      repeat (20) @(posedge mclk)
      begin
        ext <= 8'($urandom);
        #1 seen |= (latch != 8'h00);
      end
      chk("int latch", seen, 1'b1);
      pin(1'b0);
      rd(SMC_ADDR_STATUS);
      chk("fall holds", v[1:0], SMC_STOP);
      pin(1'b1);
      wait_run();
      e = warm_exp(c, div1);
      chk("warm len", n > e - 8 && n < e + 8, 1'b1);
      chk("div restart", divider < 8, 1'b1);
      rd(SMC_ADDR_SYSCR_ONE);
      chk("stop clear", v[7], 1'b0);
      rd(SMC_ADDR_SYSCR_TWO);
      chk("return mode", v[7:5], 3'h4);
    end
    wr(SMC_ADDR_SYSCR_ONE, 8'hD8);
    rd(SMC_ADDR_STATUS);
    chk("level high", v[1:0], SMC_WARM);
    pin(1'b0);
    wait_run();
    chk("warm done", cpu, 1'b1);
    wr(SMC_ADDR_SYSCR_ONE, 8'hD8);
    rd(SMC_ADDR_STATUS);
    chk("level stop", v[1:0], SMC_STOP);
    pin(1'b1);
    wait_run();
    for (int m = 0; m < 2; m++)
    begin
      mie <= 1'(m);
      wr(SMC_ADDR_SYSCR_TWO, 8'h90);
      rd(SMC_ADDR_STATUS);
      chk("idle", {v[1:0], cpu, wdg, per}, {SMC_IDLE, 3'b001});
      @(posedge mclk) wake <= 1'b1;
      seen = 1'b0;
      repeat (4) @(posedge mclk) #1 seen |= isv;
      wake <= 1'b0;
      chk("idle wake", {seen, cpu}, {1'(m), 1'b1});
    end
    pin(1'b0);
    wr(SMC_ADDR_SYSCR_ONE, 8'h98);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rd(SMC_ADDR_STATUS);
    chk("reset in stop", {v[1:0], cpu}, {SMC_NORMAL, 1'b1});
    for (int k = 0; k < 2; k++)
    begin
      wr(SMC_ADDR_SYSCR_TWO, k ? 8'hA0 : 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk("clock reset", rreq, 1'b1);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
    end
    final_report();
  end
endmodule
